// ===== sleep_pkg.sv
// Package for the sleep and power controller: register map, field
// positions, reset values, timing counts and the sleep state encoding.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package sleep_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [3:0] OFS_CONTROL     = 4'h0;
	localparam logic [3:0] OFS_GATE        = 4'h4;
	localparam logic [3:0] OFS_STATUS      = 4'h8;
	localparam logic [3:0] OFS_WAKE_ENABLE = 4'hC;

	// Control register fields
	localparam int BIT_UNLOCK    = 2;   // brownout_off_unlock
	localparam int BIT_SEL_LO    = 3;   // sleep_select low bit
	localparam int BIT_SEL_HI    = 4;   // sleep_select high bit
	localparam int BIT_ARM       = 5;   // sleep_arm
	localparam int BIT_BOD_OFF   = 7;   // brownout_sleep_off (set by the timed sequence)

	// Gate register fields
	localparam int BIT_GATE_CONV = 0;   // gate_converter
	localparam int BIT_GATE_SER  = 1;   // gate_serial_unit
	localparam int BIT_GATE_T0   = 2;   // gate_timer_zero
	localparam int BIT_GATE_T1   = 3;   // gate_timer_one

	// Wake source vector bit positions
	localparam int WK_EXT_IRQ0   = 0;
	localparam int WK_PIN_CHANGE = 1;
	localparam int WK_STORE_RDY  = 2;
	localparam int WK_SER_START  = 3;
	localparam int WK_CONV_DONE  = 4;
	localparam int WK_OTHER_IO   = 5;
	localparam int WK_WATCHDOG   = 6;
	localparam int WAKE_W        = 7;

	// Reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [3:0] GATE_RST    = 4'h0;
	localparam logic [6:0] WAKE_EN_RST = 7'h00;

	// Sleep mode encodings
	localparam logic [1:0] MODE_IDLE  = 2'h0;
	localparam logic [1:0] MODE_NOISE = 2'h1;
	localparam logic [1:0] MODE_DOWN  = 2'h2;

	// Timing figures in cycles
	localparam int UNLOCK_WINDOW = 4;   // cycles to finish the unlock
	localparam int BOD_DELAY     = 3;   // cycles until the bit is active
	localparam int BOD_HOLD      = 3;   // cycles the bit stays active
	localparam int HALT_CYCLES   = 4;   // halt after the start-up time

	// Timing in ns and derived start-up counts
	localparam int CLK_NS        = 10;
	localparam int STARTUP_NS    = 1000;
	localparam int RESET_WAKE_NS = 40000;
	localparam int STARTUP_CYC   = STARTUP_NS / CLK_NS;
	localparam int RESET_WAKE_CYC = RESET_WAKE_NS / CLK_NS;

	// Controller states, one-hot
	typedef enum logic [3:0] {
		ST_RUN   = 4'h1,   // Executing
		ST_SLEEP = 4'h2,   // Clocks gated per mode
		ST_START = 4'h4,   // Waiting out the start-up time
		ST_HALT  = 4'h8    // Four extra halt cycles
	} sleep_state_t;

endpackage : sleep_pkg

// ===== wake_if.sv
// Interface carrying the wake-source decision between the controller and
// its wake filter. Assumes both sit on the same clock.
`timescale 1ns/1ps
interface wake_if;
	import sleep_pkg::*;
	logic [1:0]        mode;      // Active sleep mode
	logic              asleep;    // Controller is in sleep
	logic [WAKE_W-1:0] events;    // Synchronised wake events
	logic [WAKE_W-1:0] enables;   // Interrupt enables
	logic              irq0_lvl;  // external_irq0 is level mode
	logic              wake;      // Qualified wake request

	modport ctrl (output mode, output asleep, output enables,
		output irq0_lvl, input events, input wake);
	modport filt (input mode, input asleep, input enables,
		input irq0_lvl, output events, output wake);
endinterface : wake_if

// ===== wake_filter.sv
// Wake filter: synchronises raw wake lines (three stages, change counts
// when stages two and three agree) and masks them per sleep mode.
// Assumes raw event lines are asynchronous levels.
`timescale 1ns/1ps
module wake_filter
	import sleep_pkg::*;
(
	input  wire logic              mclk,      // System clock
	input  wire logic              nrst,      // Sync reset, active low
	input  wire logic [WAKE_W-1:0] raw_evt,   // Raw wake event levels
	wake_if.filt                   wk         // Link to the controller
);
	logic [WAKE_W-1:0] s1_ff;    // First synchroniser stage
	logic [WAKE_W-1:0] s2_ff;    // Second stage
	logic [WAKE_W-1:0] s3_ff;    // Third stage
	logic [WAKE_W-1:0] evt_ff;   // Filtered level
	logic [WAKE_W-1:0] allow;    // Sources allowed in this mode

	// Three-stage synchroniser; only s2 reads s1
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= raw_evt;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Per bit: update only once stages two and three agree
	for (genvar i = 0; i < WAKE_W; i++) begin : g_agree
		always_ff @(posedge mclk) begin
			if (!nrst)
				evt_ff[i] <= 1'b0;
			else if (s2_ff[i] == s3_ff[i])
				evt_ff[i] <= s3_ff[i];
		end
	end

	assign wk.events = evt_ff;

	// Mode mask for the wake sources
	always_comb begin
		allow = '0;
		case (wk.mode)
			MODE_IDLE: begin
				allow = '1;
			end
			MODE_NOISE: begin
				allow[WK_CONV_DONE]  = 1'b1;
				allow[WK_STORE_RDY]  = 1'b1;
				allow[WK_PIN_CHANGE] = 1'b1;
				allow[WK_WATCHDOG]   = 1'b1;
				allow[WK_SER_START]  = 1'b1;
				allow[WK_EXT_IRQ0]   = wk.irq0_lvl;
			end
			MODE_DOWN: begin
				allow[WK_SER_START]  = 1'b1;
				allow[WK_PIN_CHANGE] = 1'b1;
				allow[WK_WATCHDOG]   = 1'b1;
				allow[WK_EXT_IRQ0]   = wk.irq0_lvl;
			end
			default: begin
				allow = '0; // Reserved mode never sleeps
			end
		endcase
	end

	// An enabled, allowed event wakes the controller
	assign wk.wake = wk.asleep && |(evt_ff & wk.enables & allow);

endmodule : wake_filter

// ===== bod_unlock.sv
// Timed unlock for brownout_sleep_off: the set sequence, a three-cycle
// delay until active and a three-cycle active window.
// Assumes write strobes come from the register slave on the same clock.
`timescale 1ns/1ps
module bod_unlock
	import sleep_pkg::*;
(
	input  wire logic mclk,       // System clock
	input  wire logic nrst,       // Sync reset, active low
	input  wire logic wr,         // Control register write pulse
	input  wire logic wr_off,     // Written brownout_sleep_off value
	input  wire logic wr_unlock,  // Written brownout_off_unlock value
	output logic      unlock,     // Unlock window open
	output logic      bod_off     // brownout_sleep_off active
);
	logic [2:0] win_ff;   // Unlock window counter
	logic [2:0] dly_ff;   // Delay until active
	logic [2:0] hold_ff;  // Active window counter

	// Arm the window on the first step of the sequence
	always_ff @(posedge mclk) begin
		if (!nrst)
			win_ff <= 3'h0;
		else if (wr && wr_off && wr_unlock)
			win_ff <= 3'(UNLOCK_WINDOW);
		else if (win_ff != 3'h0)
			win_ff <= win_ff - 3'h1;
	end

	// Second step inside the window starts the delay
	always_ff @(posedge mclk) begin
		if (!nrst)
			dly_ff <= 3'h0;
		else if (wr && wr_off && !wr_unlock && win_ff != 3'h0)
			dly_ff <= 3'(BOD_DELAY);
		else if (dly_ff != 3'h0)
			dly_ff <= dly_ff - 3'h1;
	end

	// Bit active for three cycles after the delay, then self clears
	always_ff @(posedge mclk) begin
		if (!nrst)
			hold_ff <= 3'h0;
		else if (dly_ff == 3'h1)
			hold_ff <= 3'(BOD_HOLD);
		else if (hold_ff != 3'h0)
			hold_ff <= hold_ff - 3'h1;
	end

	assign unlock  = (win_ff != 3'h0);
	assign bod_off = (hold_ff != 3'h0);

endmodule : bod_unlock

// ===== sleep_ctrl.sv
// Functional notes
// - Idle stops cpu and flash clocks
// - Noise mode also stops I/O clock
// - Power-down stops oscillator and all clocks
// - Sleep needs arm bit; mode sampled then
// - Wake holds cpu four cycles past start-up
// - Wake preserves registers and static memory
// - Reset during sleep restarts at vector
// - Idle: every interrupt source can wake
// - Noise mode: limited wake sources
// - Power-down: fewer wake sources still
// - Deep modes wake on level irq0 only
// - Idle/noise entry starts a conversion
// - Brownout off bit kills detector in power-down
// - Detector off at entry, on at wake
// - Detector off means reset-length wake delay
// - Brownout off bit needs unlock sequence
// - Unlock within four; active three, clears three
// - Gate bit stops clock, blocks register access
// - Ungating resumes peripheral unchanged
// - Gating applies in active and idle
// - Deep sleep disables digital input buffers
// - Converter stays on; restart needs extended conversion
// - Power-down disables comparator unless reference used
// - Mode 11 is reserved
// - Gate bits: 3 t1, 2 t0, 1 serial, 0 converter
//
// Top of the sleep and power controller: Avalon-MM slave, sleep state
// machine and clock-enable outputs for each domain.
// Assumes the core pulses sleep_instr for one cycle and stalls on cpu_halt.
`timescale 1ns/1ps
module sleep_ctrl
	import sleep_pkg::*;
#(
	parameter int STARTUP    = STARTUP_CYC,     // Normal start-up cycles
	parameter int RESET_WAKE = RESET_WAKE_CYC   // Reset-length start-up
)(
	input  wire logic              mclk,          // 100 MHz clock
	input  wire logic              nrst,          // Sync reset, active low
	input  wire logic [3:0]        avs_address,   // Byte address
	input  wire logic              avs_read,      // Read strobe
	input  wire logic              avs_write,     // Write strobe
	input  wire logic [3:0]        avs_byteenable, // Byte lanes
	input  wire logic [31:0]       avs_writedata, // Write data
	output logic [31:0]            avs_readdata,  // Read data
	output logic                   avs_waitrequest, // Stall
	input  wire logic              sleep_instr,   // Core executes sleep
	input  wire logic [WAKE_W-1:0] wake_raw,      // Raw wake sources
	input  wire logic              irq0_level,    // external_irq0 level mode
	input  wire logic              conv_enabled,  // Converter enabled
	input  wire logic              comp_uses_ref, // Comparator on reference
	input  wire logic              bod_fuse_on,   // brownout_level_fuse on
	output logic                   clk_en_cpu,    // cpu clock enable
	output logic                   clk_en_flash,  // flash clock enable
	output logic                   clk_en_io,     // I/O clock enable
	output logic                   clk_en_conv,   // Converter clock enable
	output logic                   fast_peripheral_clock_en, // Fast clock
	output logic                   osc_en,        // Main oscillator enable
	output logic [3:0]             periph_clk_en, // Per-peripheral enables
	output logic                   bod_en,        // Detector enable
	output logic                   comp_off,      // comparator_off force
	output logic                   input_buf_off, // Digital buffers off
	output logic                   conv_start,    // Auto conversion pulse
	output logic                   cpu_halt,      // Halt the core
	output logic                   wake_irq       // Wake: service interrupt
);
	sleep_state_t state_ff;          // Controller state
	sleep_state_t nxt_state;         // Next state
	logic [1:0]   mode_ff;           // Mode latched at entry
	logic [7:0]   control_ff;        // Control register bits
	logic [3:0]   gate_ff;           // peripheral_gate_reg
	logic [6:0]   wake_en_ff;        // Interrupt enable per source
	logic         bod_cut_ff;        // Detector off this sleep
	logic [15:0]  cnt_ff;            // Start-up and halt counter
	logic         wr_ack_ff;         // Access completes this cycle
	logic         req;               // Access pending
	logic         wr_ctl;            // Control register write pulse
	logic         unlock;            // Unlock window open
	logic         bod_off;           // brownout_sleep_off active
	logic         go_sleep;          // Qualified sleep request
	logic [31:0]  rd_mux;            // Read data mux

	wake_if wk ();

	// Wake filter and mode mask
	wake_filter u_wake (
		.mclk    (mclk),
		.nrst    (nrst),
		.raw_evt (wake_raw),
		.wk      (wk)
	);

	// Timed unlock for the brownout off bit
	bod_unlock u_bod (
		.mclk      (mclk),
		.nrst      (nrst),
		.wr        (wr_ctl),
		.wr_off    (avs_writedata[BIT_BOD_OFF]),
		.wr_unlock (avs_writedata[BIT_UNLOCK]),
		.unlock    (unlock),
		.bod_off   (bod_off)
	);

	assign wk.mode     = mode_ff;
	assign wk.asleep   = (state_ff == ST_SLEEP);
	assign wk.enables  = wake_en_ff;
	assign wk.irq0_lvl = irq0_level;

	// Bus access: every access waits one cycle, then completes
	assign req    = avs_read || avs_write;
	assign wr_ctl = avs_write && wr_ack_ff && avs_byteenable[0]
		&& (avs_address == OFS_CONTROL);

	// One-cycle wait state, cleared on the completing edge
	always_ff @(posedge mclk) begin
		if (!nrst)
			wr_ack_ff <= 1'b0;
		else
			wr_ack_ff <= req && !wr_ack_ff;
	end

	always_comb begin
		avs_waitrequest = req && !wr_ack_ff;
	end

	// Control register: arm and mode bits, written by software
	always_ff @(posedge mclk) begin
		if (!nrst)
			control_ff <= CONTROL_RST;
		else if (wr_ctl) begin
			control_ff[BIT_ARM]    <= avs_writedata[BIT_ARM];
			control_ff[BIT_SEL_HI] <= avs_writedata[BIT_SEL_HI];
			control_ff[BIT_SEL_LO] <= avs_writedata[BIT_SEL_LO];
		end
	end

	// Gate and wake enable registers
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			gate_ff    <= GATE_RST;
			wake_en_ff <= WAKE_EN_RST;
		end else if (avs_write && wr_ack_ff && avs_byteenable[0]) begin
			if (avs_address == OFS_GATE)
				gate_ff <= avs_writedata[3:0];
			if (avs_address == OFS_WAKE_ENABLE)
				wake_en_ff <= avs_writedata[6:0];
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			OFS_CONTROL: begin
				rd_mux[BIT_BOD_OFF] = bod_off;
				rd_mux[BIT_ARM]     = control_ff[BIT_ARM];
				rd_mux[BIT_SEL_HI]  = control_ff[BIT_SEL_HI];
				rd_mux[BIT_SEL_LO]  = control_ff[BIT_SEL_LO];
				rd_mux[BIT_UNLOCK]  = unlock;
			end
			OFS_GATE:        rd_mux[3:0] = gate_ff;
			OFS_STATUS: begin
				rd_mux[3:0] = state_ff;
				rd_mux[5:4] = mode_ff;
				rd_mux[6]   = bod_cut_ff;
			end
			OFS_WAKE_ENABLE: rd_mux[6:0] = wake_en_ff;
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data registered on the edge that ends the wait cycle
	always_ff @(posedge mclk) begin
		if (!nrst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !wr_ack_ff)
			avs_readdata <= rd_mux;
	end

	// Sleep only when armed and the mode is not reserved
	assign go_sleep = sleep_instr && control_ff[BIT_ARM]
		&& ({control_ff[BIT_SEL_HI], control_ff[BIT_SEL_LO]}
		!= 2'h3);

	// State transitions; reset in any state returns to run
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RUN:   if (go_sleep) nxt_state = ST_SLEEP;
			ST_SLEEP: if (wk.wake) nxt_state = ST_START;
			ST_START: if (cnt_ff == 16'h0) nxt_state = ST_HALT;
			ST_HALT:  if (cnt_ff == 16'h0) nxt_state = ST_RUN;
			default:  nxt_state = ST_RUN;
		endcase
	end

	// State register; sync reset is the reset-vector wake
	always_ff @(posedge mclk) begin
		if (!nrst)
			state_ff <= ST_RUN;
		else
			state_ff <= nxt_state;
	end

	// Latch mode and detector cut at entry
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			mode_ff    <= MODE_IDLE;
			bod_cut_ff <= 1'b0;
		end else if (state_ff == ST_RUN && go_sleep) begin
			mode_ff    <= {control_ff[BIT_SEL_HI], control_ff[BIT_SEL_LO]};
			bod_cut_ff <= bod_off && control_ff[BIT_SEL_HI];
		end else if (state_ff == ST_HALT && cnt_ff == 16'h0)
			bod_cut_ff <= 1'b0;
	end

	// Start-up then halt counter; reset-length start if detector was cut
	always_ff @(posedge mclk) begin
		if (!nrst)
			cnt_ff <= 16'h0;
		else if (state_ff == ST_SLEEP && wk.wake)
			cnt_ff <= bod_cut_ff ? 16'(RESET_WAKE - 1)
				: 16'(STARTUP - 1);
		else if (state_ff == ST_START && cnt_ff == 16'h0)
			cnt_ff <= 16'(HALT_CYCLES - 1);
		else if (cnt_ff != 16'h0)
			cnt_ff <= cnt_ff - 16'h1;
	end

	// Clock domain enables per mode; nothing here touches memory
	// contents, so register file and static memory simply hold.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			clk_en_cpu               <= 1'b1;
			clk_en_flash             <= 1'b1;
			clk_en_io                <= 1'b1;
			clk_en_conv              <= 1'b1;
			fast_peripheral_clock_en <= 1'b1;
			osc_en                   <= 1'b1;
		end else if (nxt_state == ST_SLEEP) begin
			clk_en_cpu   <= 1'b0;
			clk_en_flash <= 1'b0;
			clk_en_io    <= (nxt_mode() == MODE_IDLE);
			clk_en_conv  <= (nxt_mode() != MODE_DOWN);
			fast_peripheral_clock_en <= (nxt_mode() == MODE_IDLE);
			osc_en       <= (nxt_mode() != MODE_DOWN);
		end else begin
			clk_en_cpu               <= (nxt_state == ST_RUN);
			clk_en_flash             <= (nxt_state == ST_RUN);
			clk_en_io                <= 1'b1;
			clk_en_conv              <= 1'b1;
			fast_peripheral_clock_en <= 1'b1;
			osc_en                   <= 1'b1;
		end
	end

	// Mode that applies in the coming cycle
	function automatic logic [1:0] nxt_mode();
		if (state_ff == ST_RUN)
			return {control_ff[BIT_SEL_HI], control_ff[BIT_SEL_LO]};
		return mode_ff;
	endfunction : nxt_mode

	// Per-peripheral gating; deep modes stop the domain clock anyway
	always_ff @(posedge mclk) begin
		if (!nrst)
			periph_clk_en <= 4'hF;
		else
			periph_clk_en <= ~gate_ff;
	end

	// Detector, comparator and input buffer controls
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			bod_en        <= 1'b0;
			comp_off      <= 1'b0;
			input_buf_off <= 1'b0;
		end else begin
			bod_en <= bod_fuse_on && !(nxt_state == ST_SLEEP
				&& ((state_ff == ST_RUN && bod_off
				&& control_ff[BIT_SEL_HI]) || bod_cut_ff));
			comp_off <= (nxt_state == ST_SLEEP)
				&& (nxt_mode() == MODE_DOWN) && !comp_uses_ref;
			input_buf_off <= (nxt_state == ST_SLEEP)
				&& (nxt_mode() == MODE_DOWN);
		end
	end

	// Auto conversion on idle/noise entry; converter never forced off
	always_ff @(posedge mclk) begin
		if (!nrst)
			conv_start <= 1'b0;
		else
			conv_start <= (state_ff == ST_RUN) && go_sleep && conv_enabled
				&& !control_ff[BIT_SEL_HI];
	end

	// Halt the core except while running; pulse to service on wake
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cpu_halt <= 1'b0;
			wake_irq <= 1'b0;
		end else begin
			cpu_halt <= (nxt_state != ST_RUN);
			wake_irq <= (state_ff == ST_HALT) && (nxt_state == ST_RUN);
		end
	end

endmodule : sleep_ctrl

// ===== sleep_ctrl_asserts.sv
// Checker: clock domains on sleep entry, detector and gating.
// Assumes it is bound to sleep_ctrl and sees only its ports.
`timescale 1ns/1ps
module sleep_ctrl_asserts
	import sleep_pkg::*;
(
	input wire logic        mclk,            // Clock
	input wire logic        nrst,            // Reset, low
	input wire logic [3:0]  avs_address,     // Address
	input wire logic        avs_write,       // Write
	input wire logic [3:0]  avs_byteenable,  // Lanes
	input wire logic [31:0] avs_writedata,   // Write data
	input wire logic        avs_waitrequest, // Stall
	input wire logic        sleep_instr,     // Sleep pulse
	input wire logic        conv_enabled,    // Converter on
	input wire logic        comp_uses_ref,   // Uses reference
	input wire logic        bod_fuse_on,     // Detector fuse
	input wire logic        clk_en_cpu,      // cpu clock
	input wire logic        clk_en_flash,    // flash clock
	input wire logic        clk_en_io,       // I/O clock
	input wire logic        clk_en_conv,     // Converter clock
	input wire logic        fast_peripheral_clock_en, // Fast clock
	input wire logic        osc_en,          // Oscillator
	input wire logic [3:0]  periph_clk_en,   // Peripheral clocks
	input wire logic        bod_en,          // Detector on
	input wire logic        comp_off,        // Comparator off
	input wire logic        input_buf_off,   // Buffers off
	input wire logic        conv_start,      // Auto conversion
	input wire logic        cpu_halt         // Core halted
);
	logic       arm_ff;  // Mirror of sleep_arm
	logic [1:0] mode_ff; // Mirror of sleep_select
	logic [3:0] gate_ff; // Mirror of the gate bits
	logic       wr_ok;   // A write is taken at this edge
	assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	// Shadow control fields as the slave takes a write
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			arm_ff  <= 1'b0;
			mode_ff <= 2'h0;
		end else if (wr_ok && avs_address == OFS_CONTROL) begin
			arm_ff  <= avs_writedata[BIT_ARM];
			mode_ff <= avs_writedata[BIT_SEL_HI:BIT_SEL_LO];
		end
	end
	// Shadow gate bits
	always_ff @(posedge mclk) begin
		if (!nrst)
			gate_ff <= 4'h0;
		else if (wr_ok && avs_address == OFS_GATE)
			gate_ff <= avs_writedata[3:0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Armed sleep taken in one mode while running
	sequence s_take(logic [1:0] m);
		sleep_instr && arm_ff && mode_ff == m && !cpu_halt;
	endsequence
	// Core stopped: cpu and flash clocks off
	sequence s_halted;
		cpu_halt && !clk_en_cpu && !clk_en_flash;
	endsequence
	a_arm_enter: assert property (
		sleep_instr && arm_ff && mode_ff != 2'h3 && !cpu_halt |=> s_halted)
		else $error("armed sleep not taken");
	a_refused_sleep: assert property (
		sleep_instr && !cpu_halt && (!arm_ff || mode_ff == 2'h3)
		|=> !cpu_halt) else $error("refused sleep taken");
	a_idle_clocks: assert property (
		s_take(MODE_IDLE) |=> s_halted ##0 (clk_en_io && clk_en_conv
		&& fast_peripheral_clock_en && osc_en))
		else $error("idle domains wrong");
	a_noise_clocks: assert property (
		s_take(MODE_NOISE) |=> s_halted ##0 (!clk_en_io && clk_en_conv
		&& !fast_peripheral_clock_en && osc_en))
		else $error("noise domains wrong");
	a_down_clocks: assert property (
		s_take(MODE_DOWN) |=> s_halted ##0 (!clk_en_io && !clk_en_conv
		&& !fast_peripheral_clock_en && !osc_en))
		else $error("down domains wrong");
	a_buf_deep: assert property (
		input_buf_off == (!clk_en_io && !clk_en_conv))
		else $error("input buffers wrong");
	a_conv_auto: assert property (
		sleep_instr && arm_ff && !mode_ff[1] && conv_enabled && !cpu_halt
		|=> ##[0:1] conv_start) else $error("no auto conversion");
	a_comp_down: assert property (
		s_take(MODE_DOWN) ##0 !comp_uses_ref |=> ##[0:1] comp_off)
		else $error("comparator left on");
	a_gate_follow: assert property (
		clk_en_io |-> periph_clk_en == ~$past(gate_ff))
		else $error("gate bits ignored");
	a_bod_back: assert property (
		$past(nrst) && !cpu_halt |-> bod_en == $past(bod_fuse_on))
		else $error("detector off in run");
endmodule : sleep_ctrl_asserts

// ===== core_model.sv
// Core-side model: turns a bench request into a one-cycle sleep
// instruction. Assumes the controller stalls it through cpu_halt.
`timescale 1ns/1ps
module core_model (
	input  wire logic mclk,       // Clock
	input  wire logic nrst,       // Reset, low
	input  wire logic go,         // Bench asks for a sleep
	input  wire logic cpu_halt,   // Core stalled
	output logic      sleep_instr // One-cycle sleep pulse
);
	// Stalled core issues nothing; one pulse per request
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sleep_instr <= 1'b0;
		end else begin
			sleep_instr <= go && !cpu_halt && !sleep_instr;
		end
	end
endmodule : core_model

// ===== sleep_mode_power_controller_bench.sv
// Bench: bus tasks, core model, per-mode sleep and wake tests.
// Assumes package and design compiled first.
`timescale 1ns/1ps
module sleep_mode_power_controller_bench
	import sleep_pkg::*;
();
	localparam int SU = 5;  // Short start-up count
	localparam int RW = 20; // Short reset-length start-up
	logic        mclk, nrst, avs_read, avs_write, go, irq0_level;
	logic [3:0]  avs_address, periph_clk_en;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [6:0]  wake_raw;
	logic        avs_waitrequest, sleep_instr, clk_en_cpu, clk_en_flash;
	logic        clk_en_io, clk_en_conv, fast_peripheral_clock_en, osc_en;
	logic        bod_en, comp_off, input_buf_off, conv_start;
	logic        cpu_halt, wake_irq;
	int          miscompares = 0, samples_checked = 0;
	int          n_irq = 0, n_conv = 0;
	wire [1:0]   cpu_clks = {clk_en_cpu, clk_en_flash};
	wire [3:0]   dom = {clk_en_io, clk_en_conv, fast_peripheral_clock_en,
		osc_en};
	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Count pulses as the clock edge samples them
	always @(posedge mclk) begin
		if (wake_irq === 1'b1) n_irq <= n_irq + 1;
		if (conv_start === 1'b1) n_conv <= n_conv + 1;
	end
	sleep_ctrl #(.STARTUP(SU), .RESET_WAKE(RW)) uut (.mclk, .nrst,
		.avs_address, .avs_read, .avs_write, .avs_byteenable(4'h1),
		.avs_writedata, .avs_readdata, .avs_waitrequest, .sleep_instr,
		.wake_raw, .irq0_level, .conv_enabled(1'b1), .comp_uses_ref(1'b0),
		.bod_fuse_on(1'b1), .clk_en_cpu, .clk_en_flash, .clk_en_io,
		.clk_en_conv, .fast_peripheral_clock_en, .osc_en, .periph_clk_en,
		.bod_en, .comp_off, .input_buf_off, .conv_start, .cpu_halt,
		.wake_irq);
	core_model cpu (.mclk, .nrst, .go, .cpu_halt, .sleep_instr);
	// Four-state compare, so an unknown never matches
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask : check
	// One access, held until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n = 0;
		@(posedge mclk);
		avs_address   <= a;
		avs_writedata <= {24'h000000, d};
		avs_write     <= w;
		avs_read      <= ~w;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) timeout();
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus
	// One sleep instruction, then let the mode settle
	task automatic nap;
		@(posedge mclk);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		repeat (4) @(negedge mclk);
	endtask : nap
	// A wake line the mode must ignore
	task automatic ignore(input int src);
		@(posedge mclk);
		wake_raw[src] <= 1'b1;
		repeat (SU + 12) @(negedge mclk);
		check(32'(cpu_halt), 32'h1);
		@(posedge mclk);
		wake_raw <= 7'h00;
	endtask : ignore
	// Raise a wake line, time the halt
	task automatic wake(input int src, input int lo);
		int n = 0;
		int k = n_irq;
		@(posedge mclk);
		wake_raw[src] <= 1'b1;
		while (cpu_halt === 1'b1 && n < lo + 10) begin
			@(negedge mclk);
			n++;
		end
		if (n >= lo + 10) timeout();
		check(32'(n >= lo), 32'h1);
		@(posedge mclk);
		wake_raw <= 7'h00;
		repeat (2) @(negedge mclk);
		check(32'(n_irq - k), 32'h1);
	endtask : wake
	task automatic note(input string s);
		$display("test %s done", s);
	endtask : note
	task automatic timeout;
		miscompares++;
		end_of_test();
	endtask : timeout
	// Counts, verdict and end of run
	task automatic end_of_test;
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		{nrst, avs_read, avs_write, go, irq0_level} = 5'h00;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		wake_raw = 7'h00;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		bus(0, OFS_CONTROL, 8'h00);
		check(rd, 32'h0);
		bus(0, 4'h6, 8'h00);
		check(rd, 32'h0);
		bus(1, OFS_WAKE_ENABLE, 8'h7F);
		bus(1, OFS_CONTROL, 8'h00);
		nap();
		check(32'(cpu_halt), 32'h0);
		bus(1, OFS_CONTROL, 8'h38);
		nap();
		check(32'(cpu_halt), 32'h0);
		note("refused");
		bus(1, OFS_CONTROL, 8'h20);
		nap();
		check(32'({cpu_clks, dom, input_buf_off}), 32'h1E);
		check(32'(n_conv), 32'h1);
		wake(WK_OTHER_IO, SU + HALT_CYCLES);
		bus(0, OFS_CONTROL, 8'h00);
		check(rd, 32'h20);
		note("idle");
		bus(1, OFS_CONTROL, 8'h28);
		nap();
		check(32'({cpu_clks, dom, input_buf_off}), 32'h0A);
		check(32'(n_conv), 32'h2);
		ignore(WK_OTHER_IO);
		wake(WK_CONV_DONE, SU + HALT_CYCLES);
		note("noise");
		bus(1, OFS_CONTROL, 8'h30);
		nap();
		check(32'({cpu_clks, dom, input_buf_off, comp_off, bod_en}),
			32'h07);
		ignore(WK_EXT_IRQ0);
		ignore(WK_STORE_RDY);
		wake(WK_PIN_CHANGE, SU + HALT_CYCLES);
		@(posedge mclk);
		irq0_level <= 1'b1;
		nap();
		wake(WK_EXT_IRQ0, SU + HALT_CYCLES);
		note("power-down");
		bus(1, OFS_CONTROL, 8'hB0);
		nap();
		check(32'(bod_en), 32'h1);
		wake(WK_PIN_CHANGE, SU + HALT_CYCLES);
		bus(1, OFS_CONTROL, 8'hB4);
		bus(1, OFS_CONTROL, 8'hB0);
		@(posedge mclk);
		nap();
		check(32'(bod_en), 32'h0);
		wake(WK_PIN_CHANGE, RW + HALT_CYCLES);
		check(32'(bod_en), 32'h1);
		note("brownout");
		bus(1, OFS_GATE, 8'h0A);
		bus(0, OFS_GATE, 8'h00);
		check(rd, 32'hA);
		check(32'(periph_clk_en), 32'h5);
		bus(1, OFS_GATE, 8'h00);
		repeat (2) @(negedge mclk);
		check(32'(periph_clk_en), 32'hF);
		note("gating");
		bus(1, OFS_CONTROL, 8'h20);
		nap();
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		@(negedge mclk);
		check(32'({cpu_halt, cpu_clks}), 32'h3);
		note("reset in sleep");
		end_of_test();
	end
endmodule : sleep_mode_power_controller_bench

bind sleep_ctrl sleep_ctrl_asserts chk (.*);
